/* sbs_regs.vh */
`ifndef SBS_REGS_VH
`define SBS_REGS_VH
`define SBS_ADDR_W 20
`define SBS_DATA_W 18
`define SBS_SYNC_STAGES 2
`define SBS_SLEEP_ENTRY_CYC 2
`define SBS_SLEEP_RECOV_CYC 2
`define SBS_BURST_LEN 4
`endif

/* sbs_burst_counter.v */
`timescale 1ns/1ps
`include "sbs_regs.vh"
module sbs_burst_counter (
  input wire mclk,
  input wire rst,
  input wire load,
  input wire step,
  input wire burst_order_select,
  input wire [1:0] start_low,
  output wire [1:0] burst_low
);
  reg [1:0] count;
  reg [1:0] base;
  wire [1:0] next_count;
  assign next_count = count + 2'h1;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= 2'h0;
      base <= 2'h0;
    end else if (load) begin
      count <= 2'h0;
      base <= start_low;
    end else if (step) begin
      count <= next_count;
    end
  end
  // Address of the coming step; interleave xors the next count, linear adds it
  assign burst_low = burst_order_select ? (base ^ next_count) : (base + next_count);
endmodule // sbs_burst_counter

/* sbs_sram_ctrl.v */
`timescale 1ns/1ps
`include "sbs_regs.vh"
// Operation
// - Interleaved burst addresses are the start low bits xored with 0, 1, 2, 3 in turn.
// - After four addresses the counter is back to the loaded value on the fourth advance.
// - Sleep is entered four cycles after the sleep request rises: two synchroniser stages, then two counted cycles.
// - Address, burst context and burst counter are held unchanged while asleep.
// - Normal operation resumes five cycles after the sleep request falls.
// - While asleep every input but the sleep request and reset is ignored and the data output floats.
// - While asleep the memory is deselected and does no access.
// - The sleep request is asynchronous, active high, and sleep lasts while it is high.
// - A static input picks flow-through or registered pipelined read output.
// - The burst order input picks linear when low and interleaved when high.
// - Advance high steps the burst counter while a burst is active, advance low with select loads a new start address.
module sbs_sram_ctrl (
  input wire mclk,
  input wire rst,
  input wire sleep_request,
  input wire burst_order_select,
  input wire flow_through_select,
  input wire advance_or_load,
  input wire select,
  input wire write_en,
  input wire [`SBS_ADDR_W-1:0] addr_in,
  input wire [`SBS_DATA_W-1:0] wdata,
  input wire [`SBS_DATA_W-1:0] mem_rdata,
  output reg [`SBS_ADDR_W-1:0] mem_addr,
  output reg mem_we,
  output reg mem_re,
  output reg [`SBS_DATA_W-1:0] mem_wdata,
  output reg [`SBS_DATA_W-1:0] dq_out,
  output reg dq_oe_n,
  output reg asleep,
  output reg recovering
);
  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_SLEEP = 3'h2;
  localparam [2:0] ST_WAKE = 3'h4;

  reg sync1;
  reg sync2;
  reg [2:0] state;
  reg [1:0] cnt;
  reg [`SBS_ADDR_W-1:0] base_addr;
  reg burst_active;
  reg rd_pend;
  reg [`SBS_DATA_W-1:0] pipe_data;
  reg pipe_valid;
  wire [1:0] burst_low;
  wire active;
  wire do_load;
  wire do_step;
  wire [`SBS_ADDR_W-1:0] next_addr;
  reg [2:0] next_state;
  reg [1:0] next_cnt;
  reg next_we;
  reg next_re;
  reg [`SBS_DATA_W-1:0] next_dq_out;
  reg next_dq_oe_n;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= sleep_request;
      sync2 <= sync1;
    end
  end

  // Entry and wake delays counted from the synchronised level
  always @* begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ST_RUN: begin
        if (!sync2) begin
          next_cnt = 2'h0;
        end else if (cnt == `SBS_SLEEP_ENTRY_CYC - 1) begin
          next_state = ST_SLEEP;
          next_cnt = 2'h0;
        end else begin
          next_cnt = cnt + 2'h1;
        end
      end
      ST_SLEEP: begin
        if (!sync2) begin
          next_state = ST_WAKE;
          next_cnt = 2'h0;
        end
      end
      ST_WAKE: begin
        if (sync2) begin
          next_state = ST_SLEEP;
        end else if (cnt == `SBS_SLEEP_RECOV_CYC - 1) begin
          next_state = ST_RUN;
          next_cnt = 2'h0;
        end else begin
          next_cnt = cnt + 2'h1;
        end
      end
      default: begin
        next_state = ST_RUN;
        next_cnt = 2'h0;
      end
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_RUN;
      cnt <= 2'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Inputs ignored outside run state
  assign active = (state == ST_RUN);
  assign do_load = active && select && !advance_or_load;
  assign do_step = active && burst_active && advance_or_load;

  sbs_burst_counter u_burst (
    .mclk(mclk),
    .rst(rst),
    .load(do_load),
    .step(do_step),
    .burst_order_select(burst_order_select),
    .start_low(addr_in[1:0]),
    .burst_low(burst_low)
  );

  assign next_addr = {base_addr[`SBS_ADDR_W-1:2], burst_low};

  // One access per taken cycle; write enable picks its kind
  always @* begin
    next_we = 1'b0;
    next_re = 1'b0;
    if (do_load || do_step) begin
      next_we = write_en;
      next_re = !write_en;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      base_addr <= {`SBS_ADDR_W{1'b0}};
      burst_active <= 1'b0;
      mem_addr <= {`SBS_ADDR_W{1'b0}};
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      mem_wdata <= {`SBS_DATA_W{1'b0}};
      rd_pend <= 1'b0;
    end else if (!active) begin
      // Deselected; address and burst context frozen
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      rd_pend <= 1'b0;
    end else if (do_load) begin
      base_addr <= addr_in;
      burst_active <= 1'b1;
      mem_addr <= addr_in;
      mem_we <= next_we;
      mem_re <= next_re;
      mem_wdata <= wdata;
      rd_pend <= next_re;
    end else if (do_step) begin
      mem_addr <= next_addr;
      mem_we <= next_we;
      mem_re <= next_re;
      mem_wdata <= wdata;
      rd_pend <= next_re;
    end else begin
      if (!advance_or_load) begin
        burst_active <= 1'b0;
      end
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      rd_pend <= 1'b0;
    end
  end

  // Read data source: flow-through taps the array, pipeline the extra stage
  always @* begin
    next_dq_out = dq_out;
    next_dq_oe_n = 1'b1;
    if (!active) begin
      next_dq_oe_n = 1'b1;
    end else if (!flow_through_select) begin
      next_dq_out = mem_rdata;
      next_dq_oe_n = !rd_pend;
    end else begin
      next_dq_out = pipe_data;
      next_dq_oe_n = !pipe_valid;
    end
  end

  // Output path: flow-through drives one stage after access, pipeline one more
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pipe_data <= {`SBS_DATA_W{1'b0}};
      pipe_valid <= 1'b0;
      dq_out <= {`SBS_DATA_W{1'b0}};
      dq_oe_n <= 1'b1;
      asleep <= 1'b0;
      recovering <= 1'b0;
    end else begin
      asleep <= (state == ST_SLEEP);
      recovering <= (state == ST_WAKE);
      pipe_data <= mem_rdata;
      pipe_valid <= rd_pend && active;
      dq_out <= next_dq_out;
      dq_oe_n <= next_dq_oe_n;
    end
  end
endmodule // sbs_sram_ctrl

/* sbs_sram_ctrl_asserts.sv */
`timescale 1ns/1ps
module sbs_chk (
  input wire mclk,
  input wire rst,
  input wire sleep_request,
  input wire burst_order_select,
  input wire flow_through_select,
  input wire advance_or_load,
  input wire select,
  input wire [19:0] mem_addr,
  input wire mem_we,
  input wire mem_re,
  input wire dq_oe_n,
  input wire asleep,
  input wire recovering
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sleep_idle_a: assert property (asleep |-> !mem_we && !mem_re) else $error("access");
  sleep_float_a: assert property (asleep |-> dq_oe_n) else $error("driven");
  sleep_entry_a: assert property (sleep_request [*7] |-> asleep) else $error("awake");
  entry_delay_a: assert property ($rose(sleep_request) && !asleep && !recovering
    |-> !asleep [*4]) else $error("early");
  wake_time_a: assert property (!sleep_request [*8] |-> !asleep && !recovering)
    else $error("asleep");
  read_lat_a: assert property (!dq_oe_n
    |-> (flow_through_select ? $past(mem_re, 2) : $past(mem_re))) else $error("latency");
  access_cause_a: assert property (mem_we || mem_re
    |-> $past(select || advance_or_load)) else $error("stray");
  burst_step_a: assert property ((mem_we || mem_re) && $past(mem_we || mem_re)
    && $past(advance_or_load) |-> mem_addr[19:2] == $past(mem_addr[19:2])
    && (burst_order_select ? mem_addr[0] != $past(mem_addr[0])
    : mem_addr[1:0] == $past(mem_addr[1:0]) + 2'h1)) else $error("step");
endmodule // sbs_chk
bind sbs_sram_ctrl sbs_chk chk (.*);

/* sbs_array_model.sv */
`timescale 1ns/1ps
module sbs_array_model (
  input wire mclk,
  input wire [19:0] mem_addr,
  input wire mem_we,
  input wire [17:0] mem_wdata,
  output wire [17:0] mem_rdata
);
  reg [17:0] mem [0:15];
  always @(posedge mclk) begin
    if (mem_we) mem[mem_addr[3:0]] <= mem_wdata;
  end
  assign mem_rdata = mem[mem_addr[3:0]];
endmodule // sbs_array_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
  reg mclk = 0, rst = 1, sleep_request = 0, burst_order_select = 1;
  reg flow_through_select = 0, advance_or_load = 0, select = 0, write_en = 0;
  reg [19:0] addr_in = 0;
  reg [17:0] wdata = 0;
  reg [1:0] st = 0;
  wire [17:0] mem_rdata, mem_wdata, dq_out;
  wire [19:0] mem_addr;
  wire mem_we, mem_re, dq_oe_n, asleep, recovering;
  integer n_mismatch = 0, checks_done = 0, cyc = 0, e, k;
  sbs_sram_ctrl dut (.*);
  sbs_array_model mdl (.*);
  initial forever #2 mclk = ~mclk;
  function [1:0] nx(input [2:0] i);
    nx = burst_order_select ? st ^ i[1:0] : st + i[1:0];
  endfunction
  task chk(input [23:0] seen, input [23:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0t %h %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      n_mismatch = n_mismatch + 1;
      results;
    end
  end
  initial begin
    repeat (4) @(negedge mclk);
    rst = 0;
    for (e = 0; e < 5; e = e + 1) begin
      @(negedge mclk);
      burst_order_select = e < 4;
      st = (e < 4) ? e[1:0] : 2'h1;
      @(negedge mclk);
      select = 1;
      write_en = 1;
      addr_in = 20'h12340 | st;
      wdata = 18'h2A500 | st;
      for (k = 1; k < 7; k = k + 1) begin
        @(negedge mclk);
        if (k < 6) chk({mem_we, mem_addr}, {1'b1, 20'h12340 | nx(k[2:0] - 3'h1)});
        else chk(mem_we, 1'b0);
        select = 0;
        advance_or_load = k < 5;
        wdata = 18'h2A500 | nx(k[2:0]);
      end
    end
    write_en = 0;
    sleep_request = 1;
    repeat (8) @(negedge mclk);
    select = 1;
    repeat (3) @(negedge mclk);
    chk({asleep, dq_oe_n, mem_re}, 3'h6);
    select = 0;
    sleep_request = 0;
    repeat (8) @(negedge mclk);
    chk(asleep | recovering, 1'b0);
    for (e = 0; e < 2; e = e + 1) begin
      flow_through_select = e[0];
      @(negedge mclk);
      select = 1;
      addr_in = 20'h12342;
      for (k = 1; k < 6; k = k + 1) begin
        @(negedge mclk);
        select = 0;
        if (k == 1) chk(mem_re, 1'b1);
        if (k == 1 + e) chk(dq_oe_n, 1'b1);
        if (k == 2 + e) chk({dq_oe_n, dq_out}, 19'h2A502);
      end
    end
    results;
  end
endmodule // tb
